// ---- ssdcm_pkg.sv ----
package ssdcm_pkg;

  // Opcodes of the supported command set
  localparam logic [7:0] OP_RD_DMA      = 8'hc8;
  localparam logic [7:0] OP_RD_DMA_X    = 8'h25;
  localparam logic [7:0] OP_RD_MUL      = 8'hc4;
  localparam logic [7:0] OP_RD_MUL_X    = 8'h29;
  localparam logic [7:0] OP_RD_SEC      = 8'h20;
  localparam logic [7:0] OP_RD_SEC_X    = 8'h24;
  localparam logic [7:0] OP_WR_DMA      = 8'hca;
  localparam logic [7:0] OP_WR_DMA_X    = 8'h35;
  localparam logic [7:0] OP_WR_MUL      = 8'hc5;
  localparam logic [7:0] OP_WR_MUL_X    = 8'h39;
  localparam logic [7:0] OP_WR_SEC      = 8'h30;
  localparam logic [7:0] OP_WR_SEC_X    = 8'h34;
  localparam logic [7:0] OP_VERIFY      = 8'h40;
  localparam logic [7:0] OP_VERIFY_X    = 8'h42;
  localparam logic [7:0] OP_IDENTIFY    = 8'hec;
  localparam logic [7:0] OP_SET_FEAT    = 8'hef;
  localparam logic [7:0] OP_SET_MULT    = 8'hc6;
  localparam logic [7:0] OP_INIT_PARAM  = 8'h91;
  localparam logic [7:0] OP_DIAG        = 8'h90;
  localparam logic [7:0] OP_SEEK        = 8'h70;
  localparam logic [7:0] OP_RECAL       = 8'h10;
  localparam logic [7:0] OP_FLUSH       = 8'he7;
  localparam logic [7:0] OP_FLUSH_X     = 8'hea;
  localparam logic [7:0] OP_CHK_PWR     = 8'he5;
  localparam logic [7:0] OP_IDLE        = 8'he3;
  localparam logic [7:0] OP_IDLE_IMM    = 8'he1;
  localparam logic [7:0] OP_SLEEP       = 8'he6;
  localparam logic [7:0] OP_STANDBY     = 8'he2;
  localparam logic [7:0] OP_STANDBY_IMM = 8'he0;
  localparam logic [7:0] OP_SEC_SETPW   = 8'hf1;
  localparam logic [7:0] OP_SEC_UNLOCK  = 8'hf2;
  localparam logic [7:0] OP_SEC_ERPREP  = 8'hf3;
  localparam logic [7:0] OP_SEC_ERUNIT  = 8'hf4;
  localparam logic [7:0] OP_SEC_FREEZE  = 8'hf5;
  localparam logic [7:0] OP_SEC_DISPW   = 8'hf6;
  localparam logic [7:0] OP_TRIM        = 8'h06;
  localparam logic [7:0] OP_SMART       = 8'hb0;

  // Health attribute identifiers
  localparam logic [7:0] ATTR_INIT_BAD  = 8'ha0;
  localparam logic [7:0] ATTR_BAD       = 8'ha1;
  localparam logic [7:0] ATTR_SPARE     = 8'ha2;
  localparam logic [7:0] ATTR_MAX_ERASE = 8'ha3;
  localparam logic [7:0] ATTR_AVG_LO    = 8'ha4;
  localparam logic [7:0] ATTR_AVG_HI    = 8'ha5;

  // Flash geometry and correction strength
  localparam int PAGE_BYTES      = 4096;
  localparam int PAGES_PER_BLOCK = 128;
  localparam int BLOCK_BYTES     = 524288;
  localparam int ECC_CHUNK_BYTES = 1024;
  localparam int ECC_BITS_LOW    = 16;
  localparam int ECC_BITS_HIGH   = 24;
  localparam int SPARE_FLOOR     = 2;

  // Completion status codes
  localparam logic [1:0] ST_OK      = 2'h0;
  localparam logic [1:0] ST_ABORT   = 2'h1;
  localparam logic [1:0] ST_WR_PROT = 2'h2;
  localparam logic [1:0] ST_MEDIA   = 2'h3;

  // Block classes held in the block table
  typedef enum logic [1:0] {
    BLK_FREE   = 2'b00,
    BLK_NORMAL = 2'b01,
    BLK_BAD    = 2'b10
  } ssdcm_blk_type;

  // Command classes out of the decoder
  typedef enum logic [3:0] {
    CL_NONE   = 4'h0,
    CL_READ   = 4'h1,
    CL_WRITE  = 4'h2,
    CL_VERIFY = 4'h3,
    CL_MGMT   = 4'h4,
    CL_POWER  = 4'h5,
    CL_SEC    = 4'h6,
    CL_ERASE  = 4'h7,
    CL_TRIM   = 4'h8,
    CL_SMART  = 4'h9
  } ssdcm_class_type;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_EXEC  = 3'b001,
    S_ERASE = 3'b010,
    S_SAVE  = 3'b011,
    S_DONE  = 3'b100
  } ssdcm_state_type;

endpackage : ssdcm_pkg

// ---- ssdcm_core.sv ----
module ssdcm_core #(
  parameter int NBLK     = 16,
  parameter int ECC_HIGH = 0
) (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic                    clk_en,
  input  wire logic                    cmd_valid,
  input  wire logic [7:0]              cmd_opcode,
  input  wire logic [7:0]              cmd_feature,
  input  wire logic [$clog2(NBLK)-1:0] cmd_block,
  input  wire logic                    defect_pin,
  input  wire logic [$clog2(NBLK)-1:0] defect_block,
  input  wire logic                    low_power_pin,
  input  wire logic                    erase_pending_in,
  output logic                         cmd_ready,
  output logic                         done,
  output logic [1:0]                   status,
  output logic [15:0]                  data_out,
  output logic                         flash_prog,
  output logic                         flash_erase,
  output logic [$clog2(NBLK)-1:0]      flash_block,
  output logic                         save_req,
  output logic                         erase_pending,
  output logic                         write_locked,
  output logic                         frozen,
  output logic [4:0]                   ecc_strength
);
  localparam int BW = $clog2(NBLK);

  if (NBLK < 4 || NBLK > 256 || (NBLK & (NBLK - 1)) != 0 || ECC_HIGH < 0 || ECC_HIGH > 1) begin : g_bad_param
    $error("Unsupported NBLK or ECC_HIGH");
  end

  ssdcm_pkg::ssdcm_blk_type   tbl_reg [NBLK];
  logic [15:0]                wear_reg [NBLK];
  ssdcm_pkg::ssdcm_state_type state_reg;
  logic [BW-1:0]              blk_reg, idx_reg;
  logic [7:0]                 init_bad_reg;
  logic                       def_s1, def_s2, low_s1, low_s2, pend_s1, pend_s2;
  logic                       saved_reg, boot_reg;
  logic [1:0]                 boot_wait_reg;
  logic                       pw_set_reg, locked_reg, frz_reg, prep_reg;

  function automatic ssdcm_pkg::ssdcm_class_type classify(input logic [7:0] op);
    unique case (op)
      ssdcm_pkg::OP_RD_DMA, ssdcm_pkg::OP_RD_DMA_X, ssdcm_pkg::OP_RD_MUL,
      ssdcm_pkg::OP_RD_MUL_X, ssdcm_pkg::OP_RD_SEC,
      ssdcm_pkg::OP_RD_SEC_X:                          classify = ssdcm_pkg::CL_READ;
      ssdcm_pkg::OP_WR_DMA, ssdcm_pkg::OP_WR_DMA_X, ssdcm_pkg::OP_WR_MUL,
      ssdcm_pkg::OP_WR_MUL_X, ssdcm_pkg::OP_WR_SEC,
      ssdcm_pkg::OP_WR_SEC_X:                          classify = ssdcm_pkg::CL_WRITE;
      ssdcm_pkg::OP_VERIFY, ssdcm_pkg::OP_VERIFY_X:    classify = ssdcm_pkg::CL_VERIFY;
      ssdcm_pkg::OP_IDENTIFY, ssdcm_pkg::OP_SET_FEAT, ssdcm_pkg::OP_SET_MULT,
      ssdcm_pkg::OP_INIT_PARAM, ssdcm_pkg::OP_DIAG, ssdcm_pkg::OP_SEEK,
      ssdcm_pkg::OP_RECAL, ssdcm_pkg::OP_FLUSH,
      ssdcm_pkg::OP_FLUSH_X:                           classify = ssdcm_pkg::CL_MGMT;
      ssdcm_pkg::OP_CHK_PWR, ssdcm_pkg::OP_IDLE, ssdcm_pkg::OP_IDLE_IMM,
      ssdcm_pkg::OP_SLEEP, ssdcm_pkg::OP_STANDBY,
      ssdcm_pkg::OP_STANDBY_IMM:                       classify = ssdcm_pkg::CL_POWER;
      ssdcm_pkg::OP_SEC_SETPW, ssdcm_pkg::OP_SEC_UNLOCK, ssdcm_pkg::OP_SEC_ERPREP,
      ssdcm_pkg::OP_SEC_FREEZE, ssdcm_pkg::OP_SEC_DISPW: classify = ssdcm_pkg::CL_SEC;
      ssdcm_pkg::OP_SEC_ERUNIT:                        classify = ssdcm_pkg::CL_ERASE;
      ssdcm_pkg::OP_TRIM:                              classify = ssdcm_pkg::CL_TRIM;
      ssdcm_pkg::OP_SMART:                             classify = ssdcm_pkg::CL_SMART;
      default:                                         classify = ssdcm_pkg::CL_NONE;
    endcase
  endfunction : classify

  // Pin synchronisers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {def_s1, def_s2, low_s1, low_s2, pend_s1, pend_s2} <= 6'h00;
    end else if (clk_en) begin
      {def_s1, low_s1, pend_s1} <= {defect_pin, low_power_pin, erase_pending_in};
      {def_s2, low_s2, pend_s2} <= {def_s1, low_s1, pend_s1};
    end
  end

  // Table counts and least-worn free block
  logic [8:0]    free_cnt, bad_cnt;
  logic [15:0]   max_wear;
  logic [23:0]   wear_sum;
  logic [BW-1:0] pick_blk;
  logic          pick_ok;
  always_comb begin
    free_cnt = 9'h000;
    bad_cnt  = 9'h000;
    max_wear = 16'h0000;
    wear_sum = 24'h000000;
    pick_blk = '0;
    pick_ok  = 1'b0;
    for (int i = 0; i < NBLK; i++) begin
      wear_sum = wear_sum + 24'(wear_reg[i]);
      if (wear_reg[i] > max_wear) max_wear = wear_reg[i];
      if (tbl_reg[i] == ssdcm_pkg::BLK_BAD) bad_cnt = bad_cnt + 9'h001;
      if (tbl_reg[i] == ssdcm_pkg::BLK_FREE) begin
        free_cnt = free_cnt + 9'h001;
        if (!pick_ok || wear_reg[i] < wear_reg[pick_blk]) begin
          pick_blk = BW'(i);
          pick_ok  = 1'b1;
        end
      end
    end
  end

  wire ssdcm_pkg::ssdcm_class_type cls = classify(cmd_opcode);
  wire        lockout   = free_cnt <= 9'(ssdcm_pkg::SPARE_FLOOR);
  wire        take      = clk_en && cmd_valid && cmd_ready;
  wire        low_rise  = low_s2 && !saved_reg;
  wire [15:0] wear_avg  = 16'(wear_sum / 24'(NBLK));
  wire        defect_ev = clk_en && def_s2 && state_reg != ssdcm_pkg::S_ERASE;
  wire        wr_hit    = take && cls == ssdcm_pkg::CL_WRITE && !lockout && !locked_reg;

  // Health data selection
  logic [15:0] smart_val;
  always_comb begin
    unique case (cmd_feature)
      ssdcm_pkg::ATTR_INIT_BAD:  smart_val = {8'h00, init_bad_reg};
      ssdcm_pkg::ATTR_BAD:       smart_val = {7'h00, bad_cnt};
      ssdcm_pkg::ATTR_SPARE:     smart_val = {7'h00, free_cnt};
      ssdcm_pkg::ATTR_MAX_ERASE: smart_val = max_wear;
      ssdcm_pkg::ATTR_AVG_LO:    smart_val = {8'h00, wear_avg[7:0]};
      ssdcm_pkg::ATTR_AVG_HI:    smart_val = {8'h00, wear_avg[15:8]};
      default:                   smart_val = 16'h0000;
    endcase
  end

  // Block table and wear counters
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NBLK; i++) begin
        tbl_reg[i]  <= ssdcm_pkg::BLK_FREE;
        wear_reg[i] <= 16'h0000;
      end
    end else if (clk_en) begin
      if (state_reg == ssdcm_pkg::S_ERASE) begin
        if (tbl_reg[idx_reg] != ssdcm_pkg::BLK_BAD)
          tbl_reg[idx_reg] <= ssdcm_pkg::BLK_FREE;
        wear_reg[idx_reg] <= 16'h0000;
      end else begin
        if (wr_hit) begin
          if (tbl_reg[cmd_block] == ssdcm_pkg::BLK_NORMAL) begin
            tbl_reg[cmd_block] <= ssdcm_pkg::BLK_FREE;
            wear_reg[cmd_block] <= wear_reg[cmd_block] + 16'h0001;
          end
          tbl_reg[pick_blk] <= ssdcm_pkg::BLK_NORMAL;
        end
        if (take && cls == ssdcm_pkg::CL_TRIM && tbl_reg[cmd_block] == ssdcm_pkg::BLK_NORMAL) begin
          tbl_reg[cmd_block]  <= ssdcm_pkg::BLK_FREE;
          wear_reg[cmd_block] <= wear_reg[cmd_block] + 16'h0001;
        end
        if (defect_ev && tbl_reg[defect_block] != ssdcm_pkg::BLK_BAD) begin
          if (tbl_reg[defect_block] == ssdcm_pkg::BLK_NORMAL && pick_ok)
            tbl_reg[pick_blk] <= ssdcm_pkg::BLK_NORMAL;
          tbl_reg[defect_block] <= ssdcm_pkg::BLK_BAD;
        end
      end
    end
  end

  // Command sequencer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= ssdcm_pkg::S_IDLE;
      boot_reg     <= 1'b1;
      idx_reg      <= '0;
      blk_reg      <= '0;
      init_bad_reg <= 8'h00;
      boot_wait_reg <= 2'h3;
      saved_reg    <= 1'b0;
      pw_set_reg   <= 1'b0;
      locked_reg   <= 1'b0;
      frz_reg      <= 1'b0;
      prep_reg     <= 1'b0;
      done         <= 1'b0;
      status       <= ssdcm_pkg::ST_OK;
      data_out     <= 16'h0000;
      flash_prog   <= 1'b0;
      flash_erase  <= 1'b0;
      flash_block  <= '0;
    end else if (clk_en) begin
      done        <= 1'b0;
      flash_prog  <= 1'b0;
      flash_erase <= 1'b0;
      if (boot_wait_reg != 2'h0) begin
        boot_wait_reg <= boot_wait_reg << 1; // Pending flag crosses its synchroniser
      end else if (boot_reg) begin
        boot_reg     <= 1'b0;
        init_bad_reg <= bad_cnt[7:0];
        if (pend_s2) begin
          idx_reg   <= '0;
          state_reg <= ssdcm_pkg::S_ERASE;
        end
      end else begin
        unique case (state_reg)
          ssdcm_pkg::S_IDLE: begin
            if (low_rise) begin
              state_reg <= ssdcm_pkg::S_SAVE;
            end else if (take) begin
              state_reg <= ssdcm_pkg::S_DONE;
              status    <= ssdcm_pkg::ST_OK;
              data_out  <= 16'h0000;
              unique case (cls)
                ssdcm_pkg::CL_NONE: status <= ssdcm_pkg::ST_ABORT;
                ssdcm_pkg::CL_WRITE: begin
                  if (lockout || locked_reg) begin
                    status <= ssdcm_pkg::ST_WR_PROT;
                  end else begin
                    flash_prog  <= 1'b1;
                    flash_block <= pick_blk;
                  end
                end
                ssdcm_pkg::CL_READ, ssdcm_pkg::CL_VERIFY: begin
                  if (locked_reg) status <= ssdcm_pkg::ST_ABORT;
                  flash_block <= cmd_block;
                end
                ssdcm_pkg::CL_SMART: data_out <= smart_val;
                ssdcm_pkg::CL_SEC: begin
                  unique case (cmd_opcode)
                    ssdcm_pkg::OP_SEC_SETPW: begin
                      if (frz_reg) status <= ssdcm_pkg::ST_ABORT;
                      else pw_set_reg <= 1'b1;
                    end
                    ssdcm_pkg::OP_SEC_UNLOCK: begin
                      if (frz_reg) status <= ssdcm_pkg::ST_ABORT;
                      else locked_reg <= 1'b0;
                    end
                    ssdcm_pkg::OP_SEC_ERPREP: begin
                      if (frz_reg) status <= ssdcm_pkg::ST_ABORT;
                      else prep_reg <= 1'b1;
                    end
                    ssdcm_pkg::OP_SEC_FREEZE: frz_reg <= 1'b1;
                    default: begin
                      if (frz_reg) status <= ssdcm_pkg::ST_ABORT;
                      else begin
                        pw_set_reg <= 1'b0;
                        locked_reg <= 1'b0;
                      end
                    end
                  endcase
                end
                ssdcm_pkg::CL_ERASE: begin
                  if (frz_reg || !prep_reg) begin
                    status <= ssdcm_pkg::ST_ABORT;
                  end else begin
                    idx_reg   <= '0;
                    state_reg <= ssdcm_pkg::S_ERASE;
                  end
                end
                default: ; // Management, power and trim complete at once
              endcase
              prep_reg <= cls == ssdcm_pkg::CL_SEC && cmd_opcode == ssdcm_pkg::OP_SEC_ERPREP && !frz_reg;
              if (cls == ssdcm_pkg::CL_ERASE) prep_reg <= 1'b0;
            end
          end
          ssdcm_pkg::S_ERASE: begin
            flash_erase <= 1'b1;
            flash_block <= idx_reg;
            if (idx_reg == BW'(NBLK - 1)) begin
              state_reg  <= ssdcm_pkg::S_DONE;
              pw_set_reg <= 1'b0;
              status     <= ssdcm_pkg::ST_OK;
            end else begin
              idx_reg <= idx_reg + BW'(1);
            end
          end
          ssdcm_pkg::S_SAVE: begin
            saved_reg <= 1'b1;
            state_reg <= ssdcm_pkg::S_IDLE;
          end
          ssdcm_pkg::S_DONE: begin
            done      <= 1'b1;
            state_reg <= ssdcm_pkg::S_IDLE;
          end
          default: state_reg <= ssdcm_pkg::S_IDLE;
        endcase
      end
      if (!low_s2) saved_reg <= 1'b0;
    end
  end

  assign cmd_ready     = state_reg == ssdcm_pkg::S_IDLE && !boot_reg && !low_rise;
  assign save_req      = state_reg == ssdcm_pkg::S_SAVE;
  assign erase_pending = state_reg == ssdcm_pkg::S_ERASE;
  assign write_locked  = lockout;
  assign frozen        = frz_reg;
  assign ecc_strength  = (ECC_HIGH != 0) ? 5'(ssdcm_pkg::ECC_BITS_HIGH) : 5'(ssdcm_pkg::ECC_BITS_LOW);

endmodule : ssdcm_core

// ---- ssdcm_core_monitor.sv ----
module ssdcm_core_monitor #(
  parameter int NBLK     = 16,
  parameter int ECC_HIGH = 0
) (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       clk_en,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic       cmd_ready,
  input wire logic       done,
  input wire logic [1:0] status,
  input wire logic       low_power_pin,
  input wire logic       save_req,
  input wire logic       erase_pending,
  input wire logic       write_locked,
  input wire logic       frozen,
  input wire logic [4:0] ecc_strength
);
  localparam int ERASE_MAX = NBLK + 2;
  wire take   = clk_en && cmd_valid && cmd_ready;
  wire is_wr  = cmd_opcode inside {8'hca, 8'h35, 8'hc5, 8'h39, 8'h30, 8'h34};
  wire is_sec = cmd_opcode inside {8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf6};
  default clocking mon_cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  sequence quick_s(logic [1:0] st);
    ##2 (done && status == st);
  endsequence
  sequence slow_s(logic [1:0] st);
    ##[2:ERASE_MAX] (done && status == st);
  endsequence
  ecc_fixed_a: assert property (ecc_strength == ((ECC_HIGH != 0) ? 5'h18 : 5'h10))
    else $error("ecc strength wrong");
  done_timing_a: assert property (take && cmd_opcode != 8'hf4 |-> ##2 done)
    else $error("done not two cycles after take");
  lock_write_a: assert property (take && write_locked && is_wr |-> quick_s(ssdcm_pkg::ST_WR_PROT))
    else $error("locked write not refused");
  lock_read_a: assert property (take && write_locked && cmd_opcode == 8'h20 |-> quick_s(ssdcm_pkg::ST_OK))
    else $error("read refused under lockout");
  bad_op_a: assert property (take && cmd_opcode inside {8'h00, 8'h07, 8'hff} |-> quick_s(ssdcm_pkg::ST_ABORT))
    else $error("unknown opcode not aborted");
  frozen_sec_a: assert property (take && frozen && is_sec |-> slow_s(ssdcm_pkg::ST_ABORT))
    else $error("security op accepted while frozen");
  erase_done_a: assert property (take && cmd_opcode == 8'hf4 |-> ##[2:ERASE_MAX] done)
    else $error("erase unit too slow");
  erase_busy_a: assert property (erase_pending |-> !cmd_ready)
    else $error("command taken during erase");
  save_rise_a: assert property ($rose(low_power_pin) |-> ##[1:8] save_req)
    else $error("no save on low supply");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
endmodule : ssdcm_core_monitor

bind ssdcm_core ssdcm_core_monitor #(.NBLK(NBLK), .ECC_HIGH(ECC_HIGH)) ssdcm_core_monitor_i (
  .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
  .cmd_ready(cmd_ready), .done(done), .status(status), .low_power_pin(low_power_pin), .save_req(save_req),
  .erase_pending(erase_pending), .write_locked(write_locked), .frozen(frozen), .ecc_strength(ecc_strength));

// ---- ssdcm_host.sv ----
module ssdcm_host #(
  parameter int BW = 3
) (
  input  wire logic          ref_clk,
  input  wire logic          cmd_ready,
  input  wire logic          done,
  input  wire logic [1:0]    status,
  input  wire logic [15:0]   data_out,
  input  wire logic          flash_prog,
  input  wire logic          flash_erase,
  input  wire logic [BW-1:0] flash_block,
  output logic               cmd_valid,
  output logic [7:0]         cmd_opcode,
  output logic [7:0]         cmd_feature,
  output logic [BW-1:0]      cmd_block
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]    rsp_status;
  logic [15:0]   rsp_data;
  logic          prog_seen;
  logic [BW-1:0] prog_block;
  int            erase_cnt;
  logic          hung;
  initial begin
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_feature = 8'h00;
    cmd_block = '0;
  end
  task automatic issue(input logic [7:0] op, input logic [7:0] feat, input logic [BW-1:0] blk);
    int n;
    n = 0;
    prog_seen = 1'b0;
    erase_cnt = 0;
    @(negedge ref_clk);
    cmd_feature = feat;
    cmd_block = blk;
    cmd_opcode = op;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_opcode = ~op;
    cmd_feature = ~feat;
    cmd_block = ~blk;
    while (done !== 1'b1 && n < 300) begin
      if (flash_prog === 1'b1) begin
        prog_seen = 1'b1;
        prog_block = flash_block;
      end
      if (flash_erase === 1'b1) erase_cnt++;
      @(negedge ref_clk);
      n++;
    end
    hung = (n >= 300);
    rsp_status = status;
    rsp_data = data_out;
  endtask : issue
endmodule : ssdcm_host

// ---- tb_ssd_command_and_flash_mgmt.sv ----
module tb_ssd_command_and_flash_mgmt;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NB = 8;
  logic          ref_clk, resetn, clk_en, defect_pin, low_power_pin, erase_pending_in;
  logic          cmd_valid, cmd_ready, done, flash_prog, flash_erase, save_req, erase_pending, write_locked, frozen;
  logic [7:0]    cmd_opcode, cmd_feature;
  logic [2:0]    cmd_block, flash_block, defect_block;
  logic [1:0]    status;
  logic [15:0]   data_out;
  logic [4:0]    ecc_strength;
  logic [NB-1:0] used_m;
  int            bad_count;
  int            cmp_count;

  ssdcm_core #(.NBLK(NB), .ECC_HIGH(0)) ssdcm_core_i (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_feature(cmd_feature), .cmd_block(cmd_block), .defect_pin(defect_pin), .defect_block(defect_block),
    .low_power_pin(low_power_pin), .erase_pending_in(erase_pending_in), .cmd_ready(cmd_ready), .done(done),
    .status(status), .data_out(data_out), .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_block(flash_block), .save_req(save_req), .erase_pending(erase_pending),
    .write_locked(write_locked), .frozen(frozen), .ecc_strength(ecc_strength));
  ssdcm_host #(.BW(3)) ssdcm_host_i (
    .ref_clk(ref_clk), .cmd_ready(cmd_ready), .done(done), .status(status), .data_out(data_out),
    .flash_prog(flash_prog), .flash_erase(flash_erase), .flash_block(flash_block), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_feature(cmd_feature), .cmd_block(cmd_block));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic run(input logic [7:0] op, input logic [7:0] feat, input logic [2:0] blk);
    ssdcm_host_i.issue(op, feat, blk);
    if (ssdcm_host_i.hung) begin
      bad_count++;
      results();
    end
  endtask : run
  task automatic chk_st(input logic [1:0] exp);
    check(16'(ssdcm_host_i.rsp_status), 16'(exp));
  endtask : chk_st
  task automatic attr(input logic [7:0] id, input logic [15:0] exp);
    run(ssdcm_pkg::OP_SMART, id, 3'h0);
    chk_st(ssdcm_pkg::ST_OK);
    check(ssdcm_host_i.rsp_data, exp);
  endtask : attr
  function automatic logic [2:0] pick(input logic v);
    for (int k = 0; k < NB; k++) begin
      if (used_m[k] == v) return 3'(k);
    end
    return 3'h0;
  endfunction : pick
  task automatic do_reset(input logic pend);
    @(negedge ref_clk);
    resetn = 1'b0;
    erase_pending_in = pend;
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
  endtask : do_reset
  task automatic defect(input logic [2:0] b);
    @(negedge ref_clk);
    defect_block = b;
    defect_pin = 1'b1;
    @(negedge ref_clk);
    defect_pin = 1'b0;
    repeat (5) @(negedge ref_clk);
  endtask : defect
  task automatic t_reset();
    do_reset(1'b0);
    repeat (3) @(negedge ref_clk);
    check(16'(ecc_strength), 16'h0010);
    check(16'(write_locked), 16'h0000);
    check(16'(frozen), 16'h0000);
    attr(ssdcm_pkg::ATTR_SPARE, 16'h0008);
    attr(ssdcm_pkg::ATTR_INIT_BAD, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_decode();
    logic [7:0] ops [0:22] = '{8'hc8, 8'h25, 8'hc4, 8'h29, 8'h20, 8'h24, 8'h40, 8'h42, 8'hec, 8'hef, 8'hc6, 8'h91,
                               8'h90, 8'h70, 8'h10, 8'he7, 8'hea, 8'he5, 8'he3, 8'he1, 8'he6, 8'he2, 8'he0};
    logic [7:0] unk [0:2] = '{8'h00, 8'h07, 8'hff};
    for (int i = 0; i < 23; i++) begin
      run(ops[i], 8'h00, 3'h0);
      chk_st(ssdcm_pkg::ST_OK);
      check(16'(ssdcm_host_i.prog_seen), 16'h0000);
    end
    for (int i = 0; i < 3; i++) begin
      run(unk[i], 8'h00, 3'h0);
      chk_st(ssdcm_pkg::ST_ABORT);
    end
    attr(ssdcm_pkg::ATTR_SPARE, 16'h0008);
    $display("test decode done");
  endtask : t_decode
  task automatic t_write();
    logic [7:0] wr [0:5] = '{8'hca, 8'h35, 8'hc5, 8'h39, 8'h30, 8'h34};
    for (int i = 0; i < 6; i++) begin
      run(wr[i], 8'h00, pick(1'b0));
      chk_st(ssdcm_pkg::ST_OK);
      check(16'(ssdcm_host_i.prog_seen), 16'h0001);
      check(16'(used_m[ssdcm_host_i.prog_block]), 16'h0000);
      used_m[ssdcm_host_i.prog_block] = 1'b1;
    end
    check(16'(write_locked), 16'h0001);
    attr(ssdcm_pkg::ATTR_SPARE, 16'h0002);
    run(8'hca, 8'h00, pick(1'b0));
    chk_st(ssdcm_pkg::ST_WR_PROT);
    check(16'(ssdcm_host_i.prog_seen), 16'h0000);
    run(8'h20, 8'h00, pick(1'b1));
    chk_st(ssdcm_pkg::ST_OK);
    $display("test write done");
  endtask : t_write
  task automatic t_blocks();
    logic [2:0] b;
    b = pick(1'b1);
    run(ssdcm_pkg::OP_TRIM, 8'h00, b);
    chk_st(ssdcm_pkg::ST_OK);
    used_m[b] = 1'b0;
    attr(ssdcm_pkg::ATTR_SPARE, 16'h0003);
    attr(ssdcm_pkg::ATTR_MAX_ERASE, 16'h0001);
    check(16'(write_locked), 16'h0000);
    defect(pick(1'b0));
    attr(ssdcm_pkg::ATTR_SPARE, 16'h0002);
    attr(ssdcm_pkg::ATTR_BAD, 16'h0001);
    b = pick(1'b1);
    defect(b);
    attr(ssdcm_pkg::ATTR_SPARE, 16'h0001);
    attr(ssdcm_pkg::ATTR_BAD, 16'h0002);
    run(8'hc8, 8'h00, b);
    chk_st(ssdcm_pkg::ST_OK);
    $display("test blocks done");
  endtask : t_blocks
  task automatic t_secure();
    logic [7:0] op [0:5] = '{8'hf1, 8'hf2, 8'hf6, 8'hf4, 8'hf3, 8'hf4};
    logic [1:0] st [0:5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0};
    for (int i = 0; i < 6; i++) begin
      run(op[i], 8'h00, 3'h0);
      chk_st(st[i]);
    end
    check(16'(ssdcm_host_i.erase_cnt), 16'(NB));
    attr(ssdcm_pkg::ATTR_MAX_ERASE, 16'h0000);
    attr(ssdcm_pkg::ATTR_AVG_LO, 16'h0000);
    attr(ssdcm_pkg::ATTR_AVG_HI, 16'h0000);
    attr(ssdcm_pkg::ATTR_SPARE, 16'h0006);
    run(8'hf5, 8'h00, 3'h0);
    chk_st(ssdcm_pkg::ST_OK);
    check(16'(frozen), 16'h0001);
    run(8'hf1, 8'h00, 3'h0);
    chk_st(ssdcm_pkg::ST_ABORT);
    $display("test secure done");
  endtask : t_secure
  task automatic t_power();
    int n;
    n = 0;
    @(negedge ref_clk);
    clk_en = 1'b0;
    defect(3'h2);
    clk_en = 1'b1;
    attr(ssdcm_pkg::ATTR_SPARE, 16'h0006);
    @(negedge ref_clk);
    low_power_pin = 1'b1;
    while (save_req !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    check(16'(save_req), 16'h0001);
    if (n >= 10) results();
    low_power_pin = 1'b0;
    repeat (5) @(negedge ref_clk);
    $display("test power done");
  endtask : t_power
  task automatic t_resume();
    logic seen;
    seen = 1'b0;
    do_reset(1'b1);
    for (int i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      if (i == 3) erase_pending_in = 1'b0;
      if (erase_pending === 1'b1) seen = 1'b1;
    end
    check(16'(seen), 16'h0001);
    check(16'(erase_pending), 16'h0000);
    check(16'(cmd_ready), 16'h0001);
    $display("test resume done");
  endtask : t_resume

  initial begin
    resetn = 1'b0;
    defect_pin = 1'b0;
    defect_block = 3'h0;
    clk_en = 1'b1;
    low_power_pin = 1'b0;
    erase_pending_in = 1'b0;
    used_m = '0;
    bad_count = 0;
    cmp_count = 0;
    t_reset();
    t_decode();
    t_write();
    t_blocks();
    t_secure();
    t_power();
    t_resume();
    results();
  end
endmodule : tb_ssd_command_and_flash_mgmt
